// *** rtl/fbl_top.v ***
// flash boot-mode loader: control registers, mode straps, boot serial loader
`include "fbl_defines.vh"
module fbl_top #(
	parameter MW   = 20, // low-period counter width
	parameter DIVW = 16, // bit-rate divisor width
	parameter AW   = 11  // program RAM address width
) (
	input  wire            clk_sys,
	input  wire            rst_n,
	input  wire [5:0]      avs_address,
	input  wire            avs_read,
	input  wire            avs_write,
	input  wire [31:0]     avs_writedata,
	output reg  [31:0]     avs_readdata,
	output reg             avs_waitrequest,
	input  wire            test_pin,
	input  wire            nmi_pin,
	input  wire            boot_select_port_pin,
	input  wire            programmer_select_pin_a,
	input  wire            programmer_select_pin_b,
	input  wire            programmer_select_pin_c,
	input  wire            rxd,
	output reg             txd_o,
	output reg             txd_oe,
	input  wire            subactive,
	input  wire            wdt_overflow,
	input  wire            flash_blank,
	input  wire            erase_done,
	input  wire            erase_fail,
	output reg  [1:0]      op_mode,
	output reg             boot_active,
	output reg             flash_powerdown,
	output reg             erase_req,
	output reg             branch_pulse,
	output reg  [15:0]     branch_addr,
	output reg             serial_rx_enable,
	output reg             serial_tx_enable
);
	// ----------------------------------------------------------------
	// boot sequencer states
	// ----------------------------------------------------------------
	localparam S_IDLE   = 4'h0;
	localparam S_READY  = 4'h1;
	localparam S_FALL   = 4'h2;
	localparam S_LOW    = 4'h3;
	localparam S_ADJ    = 4'h4;
	localparam S_HAND   = 4'h5;
	localparam S_ERASE  = 4'h6;
	localparam S_EWAIT  = 4'h7;
	localparam S_LENHI  = 4'h8;
	localparam S_LENLO  = 4'h9;
	localparam S_DATA   = 4'ha;
	localparam S_FIN    = 4'hb;
	localparam S_DRAIN  = 4'hc;
	localparam S_BRANCH = 4'hd;
	localparam S_ABORT  = 4'he;

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	// is this offset one of the gated flash control registers
	function is_ctl;
		input [5:0] a;
		begin
			is_ctl = (a == `FBL_OFS_CTL_ONE) || (a == `FBL_OFS_CTL_TWO) ||
				(a == `FBL_OFS_ERASE_BLK) || (a == `FBL_OFS_PWR_CTL);
		end
	endfunction

	// divisor from low period; truncated, never below one
	function [DIVW-1:0] calc_div;
		input [MW-1:0] c;
		reg   [MW-1:0] q;
		begin
			q = c / {{(MW-4){1'b0}}, `FBL_LOW_BITS};
			calc_div = (q[DIVW-1:0] == {DIVW{1'b0}}) ? {{(DIVW-1){1'b0}}, 1'b1} : q[DIVW-1:0];
		end
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	reg [6:0] pin_m_q;          // first stage, read only by second
	reg [6:0] pin_s_q;          // second stage, safe to use
	wire      rx_s = pin_s_q[6];

	// pins leave the outside domain through two flops
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_m_q <= 7'h40;
			pin_s_q <= 7'h40;
		end else begin
			pin_m_q <= {rxd, programmer_select_pin_c, programmer_select_pin_b,
				programmer_select_pin_a, boot_select_port_pin, nmi_pin, test_pin};
			pin_s_q <= pin_m_q;
		end
	end

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	reg  [7:0]      ctl_one_q;   // flash_control_one
	reg  [7:0]      ctl_two_q;   // flash_control_two, status only
	reg  [7:0]      erase_blk_q; // erase_block_select
	reg             pd_inh_q;    // powerdown_inhibit
	reg             gate_q;      // control_access_gate
	reg  [AW-1:0]   ram_ptr_q;   // cpu read pointer into program RAM
	wire [7:0]      ram_rd;      // registered RAM read data
	wire            req = avs_read | avs_write;
	wire            take = req & ~avs_waitrequest;
	wire            wr_ok = take & avs_write;
	reg  [31:0]     rd_d;        // read data to be registered

	// ----------------------------------------------------------------
	// mode strap capture
	// ----------------------------------------------------------------
	reg [2:0] strap_cnt_q;  // cycles since reset release
	reg       strap_done_q; // mode has been latched

	// mode is latched a few cycles after release, once syncs settled
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			strap_cnt_q  <= 3'h0;
			strap_done_q <= 1'b0;
			op_mode      <= `FBL_MODE_NONE;
		end else if (!strap_done_q) begin
			strap_cnt_q <= strap_cnt_q + 3'h1;
			if (strap_cnt_q == `FBL_STRAP_CYC) begin
				strap_done_q <= 1'b1;
				if (!pin_s_q[0] && pin_s_q[1])
					op_mode <= `FBL_MODE_USER;
				else if (!pin_s_q[0] && !pin_s_q[1] && pin_s_q[2])
					op_mode <= `FBL_MODE_BOOT;
				else if (pin_s_q[0] && pin_s_q[5:3] == 3'h0)
					op_mode <= `FBL_MODE_PROG;
				else
					op_mode <= `FBL_MODE_NONE;
			end
		end
	end

	// ----------------------------------------------------------------
	// serial receiver
	// ----------------------------------------------------------------
	reg  [DIVW-1:0] div_q;      // bit_rate_divisor, kept after branch
	reg  [1:0]      rx_st_q;    // 0 idle, 1 start, 2 data, 3 stop
	reg  [DIVW-1:0] rx_cnt_q;   // cycles to next sample
	reg  [2:0]      rx_bit_q;   // data bit index
	reg  [7:0]      rx_sh_q;    // shift register, lsb first
	reg             rx_vld_q;   // one-cycle pulse, byte received
	wire            rx_tick = (rx_cnt_q == {DIVW{1'b0}});

	// asynchronous 8N1 frame; bad stop bit drops the byte
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_st_q  <= 2'h0;
			rx_cnt_q <= {DIVW{1'b0}};
			rx_bit_q <= 3'h0;
			rx_sh_q  <= 8'h00;
			rx_vld_q <= 1'b0;
		end else begin
			rx_vld_q <= 1'b0;
			if (!serial_rx_enable)
				rx_st_q <= 2'h0;
			else if (rx_st_q == 2'h0) begin
				if (!rx_s) begin
					rx_st_q  <= 2'h1;
					rx_cnt_q <= div_q >> 1;
				end
			end else if (!rx_tick)
				rx_cnt_q <= rx_cnt_q - {{(DIVW-1){1'b0}}, 1'b1};
			else begin
				rx_cnt_q <= div_q - {{(DIVW-1){1'b0}}, 1'b1};
				case (rx_st_q)
				2'h1: begin
					rx_st_q  <= rx_s ? 2'h0 : 2'h2; // glitch rejected
					rx_bit_q <= 3'h0;
				end
				2'h2: begin
					rx_sh_q  <= {rx_s, rx_sh_q[7:1]};
					rx_bit_q <= rx_bit_q + 3'h1;
					if (rx_bit_q == 3'h7)
						rx_st_q <= 2'h3;
				end
				default: begin
					rx_st_q  <= 2'h0;
					rx_vld_q <= rx_s;
				end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// serial transmitter
	// ----------------------------------------------------------------
	reg  [9:0]      tx_sh_q;    // stop, data, start
	reg  [3:0]      tx_left_q;  // bits still to send
	reg  [DIVW-1:0] tx_cnt_q;   // cycles left in current bit
	reg             tx_go;      // sequencer asks for a byte
	reg  [7:0]      tx_byte;    // byte to send
	wire            tx_busy = (tx_left_q != 4'h0);

	// frame out at the matched rate; idle line is high
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tx_sh_q   <= 10'h3ff;
			tx_left_q <= 4'h0;
			tx_cnt_q  <= {DIVW{1'b0}};
			txd_o     <= 1'b1;
		end else if (tx_go && !tx_busy && serial_tx_enable) begin
			tx_sh_q   <= {1'b1, tx_byte, 1'b0};
			tx_left_q <= 4'hb; // extra high bit: stop stands a full bit time
			tx_cnt_q  <= {DIVW{1'b0}};
		end else if (tx_busy) begin
			if (tx_cnt_q == {DIVW{1'b0}}) begin
				txd_o     <= tx_sh_q[0];
				tx_sh_q   <= {1'b1, tx_sh_q[9:1]};
				tx_left_q <= tx_left_q - 4'h1;
				tx_cnt_q  <= div_q - {{(DIVW-1){1'b0}}, 1'b1};
			end else
				tx_cnt_q <= tx_cnt_q - {{(DIVW-1){1'b0}}, 1'b1};
		end else
			txd_o <= 1'b1;
	end

	// ----------------------------------------------------------------
	// boot sequencer
	// ----------------------------------------------------------------
	reg  [3:0]    st_q;      // sequencer state
	reg  [MW-1:0] cnt_q;     // ready wait and low-period counter
	reg  [15:0]   len_q;     // program length from host
	reg  [15:0]   got_q;     // program bytes received
	wire          ram_we = (st_q == S_DATA) && rx_vld_q &&
		(got_q < `FBL_RAM_DEPTH);

	// send a byte: echo in load states, fixed replies in S_ADJ, S_EWAIT and S_FIN
	always @* begin
		tx_go   = 1'b0;
		tx_byte = rx_sh_q;
		case (st_q)
		S_ADJ: begin
			tx_go   = 1'b1;
			tx_byte = `FBL_BYTE_ZERO;
		end
		S_LENHI, S_LENLO, S_DATA: tx_go = rx_vld_q;
		S_FIN: begin
			tx_go   = 1'b1;
			tx_byte = `FBL_BYTE_OK;
		end
		S_ABORT: begin
			tx_go   = 1'b0; // erase-fail reply already went out on entry from S_EWAIT, send once
			tx_byte = `FBL_BYTE_FAIL;
		end
		S_EWAIT: begin
			tx_go   = erase_done || flash_blank;
			tx_byte = erase_fail ? `FBL_BYTE_FAIL : `FBL_BYTE_OK;
		end
		default: tx_go = 1'b0;
		endcase
	end

	// handshake, erase, length, program load and branch
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_q             <= S_IDLE;
			cnt_q            <= {MW{1'b0}};
			len_q            <= 16'h0000;
			got_q            <= 16'h0000;
			div_q            <= {{(DIVW-1){1'b0}}, 1'b1};
			boot_active      <= 1'b0;
			erase_req        <= 1'b0;
			branch_pulse     <= 1'b0;
			branch_addr      <= 16'h0000;
			serial_rx_enable <= 1'b0;
			serial_tx_enable <= 1'b0;
			txd_oe           <= 1'b0;
		end else begin
			erase_req    <= 1'b0;
			branch_pulse <= 1'b0;
			if (wdt_overflow && boot_active) begin
				st_q             <= S_ABORT; // parked until reset, no restart
				boot_active      <= 1'b0;
				serial_rx_enable <= 1'b0;
				serial_tx_enable <= 1'b0;
			end else
			case (st_q)
			S_IDLE: if (strap_done_q && op_mode == `FBL_MODE_BOOT && !boot_active &&
					!branch_addr[15]) begin
				st_q        <= S_READY;
				boot_active <= 1'b1;
				cnt_q       <= {MW{1'b0}};
			end
			S_READY: begin
				cnt_q <= cnt_q + {{(MW-1){1'b0}}, 1'b1};
				if (cnt_q == `FBL_READY_CYC - 1)
					st_q <= S_FALL;
			end
			S_FALL: if (rx_s) begin
				st_q  <= S_LOW;
				cnt_q <= {MW{1'b0}};
			end
			S_LOW: begin
				if (!rx_s && cnt_q != {MW{1'b1}})
					cnt_q <= cnt_q + {{(MW-1){1'b0}}, 1'b1};
				else if (rx_s && cnt_q != {MW{1'b0}}) begin
					div_q            <= calc_div(cnt_q);
					serial_tx_enable <= 1'b1;
					txd_oe           <= 1'b1;
					st_q             <= S_ADJ;
				end
			end
			S_ADJ: if (!tx_busy) begin
				st_q             <= S_HAND;
				serial_rx_enable <= 1'b1;
			end
			S_HAND: if (rx_vld_q && rx_sh_q == `FBL_BYTE_HAND)
				st_q <= S_ERASE;
			S_ERASE: begin
				erase_req <= !flash_blank;
				st_q      <= S_EWAIT;
			end
			S_EWAIT: if (flash_blank || erase_done)
				st_q <= (erase_fail && !flash_blank) ? S_ABORT : S_LENHI;
			S_LENHI: if (rx_vld_q) begin
				len_q[15:8] <= rx_sh_q;
				st_q        <= S_LENLO;
			end
			S_LENLO: if (rx_vld_q) begin
				len_q[7:0] <= rx_sh_q;
				got_q      <= 16'h0000;
				st_q       <= ({len_q[15:8], rx_sh_q} == 16'h0000) ? S_FIN : S_DATA;
			end
			S_DATA: if (rx_vld_q) begin
				got_q <= got_q + 16'h0001;
				if (got_q + 16'h0001 == len_q)
					st_q <= S_FIN;
			end
			S_FIN: if (!tx_busy)
				st_q <= S_DRAIN;
			S_DRAIN: if (!tx_busy) begin
				serial_rx_enable <= 1'b0;
				serial_tx_enable <= 1'b0;
				txd_oe           <= 1'b1;
				st_q             <= S_BRANCH;
			end
			S_BRANCH: begin
				// cpu registers are not touched; the program sets them up
				branch_pulse <= 1'b1;
				branch_addr  <= `FBL_RAM_BASE;
				boot_active  <= 1'b0;
				st_q         <= S_IDLE;
			end
			S_ABORT: if (!tx_busy && boot_active) begin
				boot_active <= 1'b0; // wait here until a reset
			end
			default: st_q <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// program RAM, offset inside the load window
	// ----------------------------------------------------------------
	fbl_ram #(
		.DW    (8),
		.AW    (AW),
		.DEPTH (`FBL_RAM_DEPTH)
	) u_ram (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.wr_en     (ram_we),
		.wr_addr   (got_q[AW-1:0]),
		.wr_data   (rx_sh_q),
		.rd_addr   (ram_ptr_q),
		.rd_data_q (ram_rd)
	);

	// ----------------------------------------------------------------
	// register read mux
	// ----------------------------------------------------------------
	// gated registers read zero while the gate is shut
	always @* begin
		rd_d = 32'h0000_0000;
		if (is_ctl(avs_address) && !gate_q)
			rd_d = 32'h0000_0000;
		else if (avs_address == `FBL_OFS_CTL_ONE)
			rd_d = {24'h000000, ctl_one_q};
		else if (avs_address == `FBL_OFS_CTL_TWO)
			rd_d = {24'h000000, ctl_two_q};
		else if (avs_address == `FBL_OFS_ERASE_BLK)
			rd_d = {24'h000000, erase_blk_q};
		else if (avs_address == `FBL_OFS_PWR_CTL)
			rd_d = {24'h000000, pd_inh_q, 7'h00};
		else if (avs_address == `FBL_OFS_ACC_EN)
			rd_d = {24'h000000, gate_q, 7'h00};
		else if (avs_address == `FBL_OFS_BOOT_STAT)
			rd_d = {20'h00000, st_q, 5'h00, boot_active, op_mode};
		else if (avs_address == `FBL_OFS_DIVISOR)
			rd_d = {{(32-DIVW){1'b0}}, div_q};
		else if (avs_address == `FBL_OFS_RAM_PTR)
			rd_d = {{(32-AW){1'b0}}, ram_ptr_q};
		else if (avs_address == `FBL_OFS_RAM_DATA)
			rd_d = {24'h000000, ram_rd};
	end

	// ----------------------------------------------------------------
	// avalon slave: one wait cycle, then the transfer completes
	// ----------------------------------------------------------------
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else begin
			avs_waitrequest <= !(req && avs_waitrequest);
			if (req && avs_waitrequest && avs_read)
				avs_readdata <= rd_d;
		end
	end

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctl_one_q   <= `FBL_RST_BYTE;
			ctl_two_q   <= `FBL_RST_BYTE;
			erase_blk_q <= `FBL_RST_BYTE;
			pd_inh_q    <= 1'b0;
			gate_q      <= 1'b0;
			ram_ptr_q   <= {AW{1'b0}};
		end else begin
			ctl_two_q <= {erase_fail, 7'h00}; // error flag, reserved low bits
			if (wr_ok && avs_address == `FBL_OFS_ACC_EN)
				gate_q <= avs_writedata[`FBL_BIT_TOP];
			else if (wr_ok && avs_address == `FBL_OFS_RAM_PTR)
				ram_ptr_q <= avs_writedata[AW-1:0];
			else if (wr_ok && is_ctl(avs_address) && gate_q) begin
				if (avs_address == `FBL_OFS_CTL_ONE)
					ctl_one_q <= {1'b0, avs_writedata[6:0]};
				else if (avs_address == `FBL_OFS_ERASE_BLK)
					erase_blk_q <= {1'b0, avs_writedata[6:0]};
				else if (avs_address == `FBL_OFS_PWR_CTL)
					pd_inh_q <= avs_writedata[`FBL_BIT_TOP];
			end
		end
	end

	// ----------------------------------------------------------------
	// flash power-down in subactive mode
	// ----------------------------------------------------------------
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			flash_powerdown <= 1'b0;
		else
			flash_powerdown <= subactive && !pd_inh_q;
	end
endmodule

// *** rtl/fbl_defines.vh ***
// constants for the flash boot-mode loader: offsets, fields, bytes, timing
// How it works
// - inhibit bit 0 lets subactive power flash down
// - reserved bits 6..0 of both registers read zero
// - enable bit 1 opens flash control registers
// - enable bit 0 blocks all control accesses
// - mode picked from test, interrupt, port pins
// - boot loads control program into on-chip RAM
// - whole flash erased before loaded program runs
// - serial framing eight data, one stop, no parity
// - measure zero-byte low time, match host rate
// - measurement ready about 100 states after reset
// - send one zero byte when rate matched
// - program stored in RAM 0xF780 to 0xFEEF
// - clear serial enables, keep divisor, then branch
// - general registers undefined at program entry
// - watchdog overflow ends boot mode
// - erase if data, reply 0xAA, else 0xFF abort
// - two length bytes high first, echo, store, 0xAA
`ifndef FBL_DEFINES_VH
`define FBL_DEFINES_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define FBL_OFS_CTL_ONE    6'h00
`define FBL_OFS_CTL_TWO    6'h04
`define FBL_OFS_ERASE_BLK  6'h08
`define FBL_OFS_PWR_CTL    6'h0c
`define FBL_OFS_ACC_EN     6'h10
`define FBL_OFS_BOOT_STAT  6'h14
`define FBL_OFS_DIVISOR    6'h18
`define FBL_OFS_RAM_PTR    6'h1c
`define FBL_OFS_RAM_DATA   6'h20
// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define FBL_BIT_TOP        7
`define FBL_RST_BYTE       8'h00
// ----------------------------------------------------------------
// operating modes
// ----------------------------------------------------------------
`define FBL_MODE_USER      2'h0
`define FBL_MODE_BOOT      2'h1
`define FBL_MODE_PROG      2'h2
`define FBL_MODE_NONE      2'h3
// ----------------------------------------------------------------
// protocol bytes and RAM window
// ----------------------------------------------------------------
`define FBL_BYTE_ZERO      8'h00
`define FBL_BYTE_HAND      8'h55
`define FBL_BYTE_OK        8'haa
`define FBL_BYTE_FAIL      8'hff
`define FBL_RAM_BASE       16'hf780
`define FBL_RAM_LAST       16'hfeef
`define FBL_RAM_DEPTH      1904
`define FBL_LOW_BITS       4'h9
// ----------------------------------------------------------------
// timing: one state is one system clock period
// ----------------------------------------------------------------
`define FBL_CLK_NS         4
`define FBL_STATE_NS       4
`define FBL_READY_STATES   100
`define FBL_READY_CYC      ((`FBL_READY_STATES*`FBL_STATE_NS+`FBL_CLK_NS-1)/`FBL_CLK_NS)
`define FBL_STRAP_CYC      4
`endif

// *** rtl/fbl_ram.v ***
// program RAM of the boot loader: one write port, one registered read port
module fbl_ram #(
	parameter DW    = 8,
	parameter AW    = 11,
	parameter DEPTH = 1904
) (
	input  wire          clk_sys,
	input  wire          rst_n,
	input  wire          wr_en,
	input  wire [AW-1:0] wr_addr,
	input  wire [DW-1:0] wr_data,
	input  wire [AW-1:0] rd_addr,
	output reg  [DW-1:0] rd_data_q
);
	reg [DW-1:0] mem [0:DEPTH-1]; // storage, no reset on purpose

	// ----------------------------------------------------------------
	// write port
	// ----------------------------------------------------------------
	always @(posedge clk_sys) begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
	end

	// ----------------------------------------------------------------
	// read port, data from a register
	// ----------------------------------------------------------------
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			rd_data_q <= {DW{1'b0}};
		else
			rd_data_q <= mem[rd_addr];
	end
endmodule

// *** testbench/fbl_top_monitor.sv ***
// port checker of the flash boot-mode loader
module fbl_top_monitor (
	input logic        clk_sys,
	input logic        rst_n,
	input logic        avs_read,
	input logic        avs_write,
	input logic        avs_waitrequest,
	input logic        subactive,
	input logic        wdt_overflow,
	input logic        flash_blank,
	input logic [1:0]  op_mode,
	input logic        boot_active,
	input logic        flash_powerdown,
	input logic        erase_req,
	input logic        branch_pulse,
	input logic [15:0] branch_addr,
	input logic        serial_rx_enable,
	input logic        serial_tx_enable,
	input logic        txd_o,
	input logic        txd_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// one clock domain, so one default clocking
	// ----
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	property p_pd; !subactive |=> !flash_powerdown; endproperty
	a_pd: assert property (p_pd) else $error("powerdown outside subactive");
	property p_wt; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
	a_wt: assert property (p_wt) else $error("bus answer late");
	property p_w1; !avs_waitrequest |=> avs_waitrequest; endproperty
	a_w1: assert property (p_w1) else $error("bus answer too long");
	property p_md; op_mode != 2'h3 |=> op_mode == $past(op_mode); endproperty
	a_md: assert property (p_md) else $error("mode changed after latch");
	property p_bm; boot_active |-> op_mode == 2'h1; endproperty
	a_bm: assert property (p_bm) else $error("boot outside boot mode");
	property p_er; erase_req |-> boot_active && !flash_blank ##1 !erase_req; endproperty
	a_er: assert property (p_er) else $error("bad erase request");
	property p_br; branch_pulse |=> !branch_pulse && !boot_active && branch_addr == 16'hf780;
	endproperty
	a_br: assert property (p_br) else $error("bad branch");
	property p_bs; branch_pulse |=> !serial_rx_enable && !serial_tx_enable && txd_oe && txd_o;
	endproperty
	a_bs: assert property (p_bs) else $error("serial state at branch");
	property p_wd; wdt_overflow && boot_active |=> ##[0:3] !boot_active; endproperty
	a_wd: assert property (p_wd) else $error("watchdog kept boot");
	property p_id; !txd_oe |-> txd_o; endproperty
	a_id: assert property (p_id) else $error("transmit idle low");
endmodule
bind fbl_top fbl_top_monitor u_mon (.*);

// *** testbench/fbl_host_model.sv ***
// host computer model on the boot serial link
module fbl_host_model #(
	parameter int BT = 32 // bit time in cycles
) (
	input  logic clk_sys,
	input  logic dev_txd,  // device transmit line
	output logic host_txd  // device receive line
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] q [$]; // bytes taken from the device
	logic [7:0] rb;    // byte being received
	initial host_txd = 1'b1;
	// ----
	// sender: start, lsb first, one stop, no parity
	// ----
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		@(posedge clk_sys);
		for (int i = 0; i < 10; i++) begin
			host_txd <= f[i];
			repeat (BT) @(posedge clk_sys);
		end
	endtask
	// ----
	// receiver: mid-bit sampling, drops a low stop bit
	// ----
	always @(posedge clk_sys) begin
		if (dev_txd === 1'b0) begin
			repeat (BT / 2) @(posedge clk_sys);
			for (int i = 0; i < 8; i++) begin
				repeat (BT) @(posedge clk_sys);
				rb[i] = dev_txd;
			end
			repeat (BT) @(posedge clk_sys);
			if (dev_txd === 1'b1) q.push_back(rb);
		end
	end
endmodule

// *** testbench/fbl_top_tb.sv ***
// self-checking bench of the flash boot-mode loader
module fbl_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BT = 32; // host bit time, wide enough for divisor rounding
	logic clk_sys, rst_n, avs_read, avs_write, avs_waitrequest, test_pin, nmi_pin;
	logic boot_select_port_pin, programmer_select_pin_a, programmer_select_pin_b;
	logic programmer_select_pin_c, rxd, txd_o, txd_oe, subactive, wdt_overflow;
	logic flash_blank, erase_done, erase_fail, boot_active, flash_powerdown;
	logic erase_req, branch_pulse, serial_rx_enable, serial_tx_enable;
	logic [5:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [1:0] op_mode;
	logic [15:0] branch_addr;
	wire txd_line = txd_oe ? txd_o : 1'b1; // board pull-up when released
	int n_fail, num_checks, cyc;
	fbl_top DUT (.*);
	fbl_host_model #(.BT(BT)) host (.clk_sys(clk_sys), .dev_txd(txd_line), .host_txd(rxd));
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	// ----
	// helpers: compare, reset, bus cycle, serial byte
	// ----
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic rst(input logic [5:0] s, input int n);
		@(posedge clk_sys);
		rst_n <= 1'b0;
		{test_pin, nmi_pin, boot_select_port_pin, programmer_select_pin_a,
			programmer_select_pin_b, programmer_select_pin_c} <= s;
		repeat (n) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk_sys);
	endtask
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic get(input logic [7:0] e);
		while (host.q.size() == 0) @(posedge clk_sys);
		chk("serial byte", host.q.pop_front(), e);
	endtask
	// reset into boot, match rate, handshake, answer the erase
	task automatic boot_go(input logic f);
		host.q.delete();
		rst(6'h0f, 20);
		while (host.q.size() == 0) host.send(8'h00);
		get(8'h00);
		repeat (20 * BT) @(posedge clk_sys);
		fork
			host.send(8'h55);
		join_none
		while (erase_req !== 1'b1) @(posedge clk_sys);
		erase_fail <= f;
		erase_done <= 1'b1;
		@(posedge clk_sys);
		erase_done <= 1'b0;
		get(f ? 8'hff : 8'haa);
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_regs();
		rst(6'h10, 4);
		bus(1'b1, 6'h0c, 32'hff);
		bus(1'b1, 6'h10, 32'hff);
		bus(1'b0, 6'h10, 32'h0);
		chk("access enable", rd, 32'h80);
		bus(1'b0, 6'h0c, 32'h0);
		chk("power control", rd, 32'h0);
		bus(1'b1, 6'h0c, 32'hff);
		bus(1'b0, 6'h0c, 32'h0);
		chk("power control", rd, 32'h80);
		subactive <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk("powerdown", flash_powerdown, 1'b0);
		bus(1'b1, 6'h0c, 32'h0);
		repeat (3) @(posedge clk_sys);
		chk("powerdown", flash_powerdown, 1'b1);
		subactive <= 1'b0;
		bus(1'b1, 6'h10, 32'h0);
		bus(1'b1, 6'h0c, 32'h80);
		bus(1'b0, 6'h0c, 32'h0);
		chk("gated read", rd, 32'h0);
		bus(1'b0, 6'h3c, 32'h0);
		chk("unmapped", rd, 32'h0);
	endtask
	task automatic t_modes();
		logic [5:0] s [4] = '{6'h10, 6'h0f, 6'h20, 6'h00};
		logic [1:0] m [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
		for (int i = 0; i < 4; i++) begin
			rst(s[i], 20);
			chk("op_mode", op_mode, m[i]);
		end
	endtask
	task automatic t_boot();
		logic [7:0] p [5] = '{8'h00, 8'h03, 8'h3c, 8'h5a, 8'hc3};
		boot_go(1'b0);
		bus(1'b0, 6'h18, 32'h0);
		chk("divisor", rd >= BT - 1 && rd <= BT + 1, 1'b1);
		foreach (p[i]) begin
			host.send(p[i]);
			get(p[i]);
		end
		get(8'haa);
		repeat (2 * BT) @(posedge clk_sys);
		chk("branch addr", branch_addr, 16'hf780);
		chk("serial enables", {serial_rx_enable, serial_tx_enable}, 2'h0);
		chk("tx pin", {txd_oe, txd_o}, 2'h3);
		bus(1'b0, 6'h18, 32'h0);
		chk("kept divisor", rd >= BT - 1 && rd <= BT + 1, 1'b1);
		bus(1'b1, 6'h1c, 32'h1);
		repeat (2) @(posedge clk_sys);
		bus(1'b0, 6'h20, 32'h0);
		chk("ram byte", rd, 32'h5a);
	endtask
	task automatic t_fail();
		boot_go(1'b1);
		repeat (2 * BT) @(posedge clk_sys);
		chk("abort", boot_active, 1'b0);
		erase_fail <= 1'b0;
		boot_go(1'b0);
		wdt_overflow <= 1'b1;
		@(posedge clk_sys);
		wdt_overflow <= 1'b0;
		repeat (4) @(posedge clk_sys);
		chk("watchdog exit", boot_active, 1'b0);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_fail++;
			end_of_test();
		end
	end
	initial begin
		{avs_read, avs_write, subactive, wdt_overflow, erase_done, erase_fail} = 6'h00;
		{test_pin, nmi_pin, boot_select_port_pin} = 3'h2;
		{programmer_select_pin_a, programmer_select_pin_b, programmer_select_pin_c} = 3'h7;
		avs_address = 6'h00;
		avs_writedata = 32'h0;
		flash_blank = 1'b0;
		rst_n = 1'b0;
		cyc = 0;
		t_regs();
		t_modes();
		t_boot();
		t_fail();
		end_of_test();
	end
endmodule
